/* rtl/oss_top.sv */
// oscillator source select: wishbone registers, reference select, oscillator pin, pll controls
`timescale 1ns/10ps
`include "oss_defines.svh"

module oss_top (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`OSS_ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // oscillators and nonvolatile option
  input  wire logic                     internalOscClk,
  input  wire logic                     rcOscClk,
  input  wire logic                     crystalOscClk,
  input  wire logic                     crystalDrive,
  input  wire logic                     busClkLevel,
  input  wire logic [7:0]               optionWord,
  input  wire logic                     stopMode,
  // clock outputs
  output logic                          pllRefClock,
  output logic                          timebaseRefClock,
  output logic                          oscOutPin,
  // oscillator enables
  output logic                          internalOscEn,
  output logic                          rcOscEn,
  output logic                          crystalOscEn,
  // pll controls
  output logic                          pllPowerOn,
  output logic                          baseClockSelect,
  output logic      [3:0]               prescaleMult,
  output logic      [2:0]               vcoRangeMult
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] pow2(input logic [1:0] e);
    pow2 = 4'h1 << e;
  endfunction

  function automatic logic hit(input logic [`OSS_ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  // ==========================================================
  // registers
  logic [7:0] setup_r;
  logic [7:0] option_r;
  logic       optLoaded_r;
  logic       pllPwr_r;
  logic       bcs_r;
  logic [1:0] pre_r;
  logic [1:0] vpr_r;

  logic       req;
  logic       wrByte0;
  logic [7:0] wd;
  logic       hitSetup;
  logic       hitOption;
  logic       hitPll;

  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrByte0   = req && wb_we_i && wb_sel_i[0];
  assign wd        = wb_dat_i[7:0];
  // setup register at its fixed index
  assign hitSetup  = hit(wb_adr_i, `OSS_IDX_SETUP);
  assign hitOption = hit(wb_adr_i, `OSS_IDX_OPTION);
  assign hitPll    = hit(wb_adr_i, `OSS_IDX_PLL);

  oss_pkg::oss_sel_t refSel;
  oss_pkg::oss_sel_t tbSel;
  assign refSel = {option_r[`OSS_OPT_REFHI], option_r[`OSS_OPT_REFLO]};
  assign tbSel  = {setup_r[`OSS_SETUP_TBHI], setup_r[`OSS_SETUP_TBLO]};

  // ==========================================================
  // bus answer: one wait state, unmapped reads zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (hitSetup) begin
        wb_dat_o <= {24'h00_0000, setup_r};
      end else if (hitOption) begin
        wb_dat_o <= {24'h00_0000, option_r};
      end else if (hitPll) begin
        wb_dat_o <= {24'h00_0000, 2'b00, pllPwr_r, bcs_r, vpr_r, pre_r};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // setup register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // reset clears select and stop bits
      setup_r <= `OSS_SETUP_RESET;
    end else if (wrByte0 && hitSetup) begin
      setup_r <= wd & `OSS_SETUP_MASK;
    end
  end

  // ==========================================================
  // option word, captured once after reset release, read only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      option_r    <= 8'h00;
      optLoaded_r <= 1'b0;
    end else if (!optLoaded_r) begin
      option_r    <= optionWord;
      optLoaded_r <= 1'b1;
    end
  end

  // ==========================================================
  // pll control with interlocks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pllPwr_r <= 1'b0;
      bcs_r    <= 1'b0;
    end else if (wrByte0 && hitPll) begin
      // power held while base select set
      pllPwr_r <= wd[`OSS_PLL_PWR] | bcs_r;
      // base select needs power from an earlier write
      bcs_r    <= wd[`OSS_PLL_BCS] & pllPwr_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 2'b00;
      vpr_r <= 2'b00;
    end else if (wrByte0 && hitPll && !pllPwr_r) begin
      pre_r <= {wd[`OSS_PLL_PREHI], wd[`OSS_PLL_PRELO]};
      vpr_r <= {wd[`OSS_PLL_VPRHI], wd[`OSS_PLL_VPRLO]};
    end
  end

  // ==========================================================
  // pll outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pllPowerOn      <= 1'b0;
      baseClockSelect <= 1'b0;
      prescaleMult    <= 4'h1;
      vcoRangeMult    <= 3'h1;
    end else begin
      pllPowerOn      <= pllPwr_r;
      baseClockSelect <= bcs_r;
      prescaleMult    <= pow2(pre_r);
      vcoRangeMult    <= 3'(pow2(vpr_r));
    end
  end

  // ==========================================================
  // reference clock and oscillator pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pllRefClock <= 1'b0;
      oscOutPin   <= 1'b0;
    end else begin
      unique case (refSel)
        `OSS_REF_INT:  pllRefClock <= internalOscClk;
        `OSS_REF_RC:   pllRefClock <= rcOscClk;
        `OSS_REF_XTAL: pllRefClock <= crystalOscClk;
        `OSS_REF_NONE: pllRefClock <= 1'b0;
      endcase
      oscOutPin <= (refSel == `OSS_REF_XTAL) ? ~crystalDrive : busClkLevel;
    end
  end

  // ==========================================================
  // timebase selector
  logic [2:0] tbAllowed;
  // rc and crystal offered only as reference
  assign tbAllowed = {refSel == `OSS_REF_XTAL, refSel == `OSS_REF_RC, 1'b1};

  oss_clk_mux u_mux (
    .clock    (clock),
    .rstn     (rstn),
    .srcLevel ({crystalOscClk, rcOscClk, internalOscClk}),
    .srcAllowed(tbAllowed),
    .sel      (tbSel),
    .clkOut_r (timebaseRefClock)
  );

  oss_osc_gate u_gate (
    .clock      (clock),
    .rstn       (rstn),
    .stopMode   (stopMode),
    .iclkDisable(setup_r[`OSS_SETUP_ICLKDIS]),
    .rcKeep     (setup_r[`OSS_SETUP_RCKEEP]),
    .xtalKeep   (setup_r[`OSS_SETUP_XKEEP]),
    .refSel     (refSel),
    .intOscEn_r (internalOscEn),
    .rcOscEn_r  (rcOscEn),
    .xtalOscEn_r(crystalOscEn)
  );

  // ==========================================================
  // checks
  sequence pllWrite;
    wrByte0 && hitPll;
  endsequence

  // power kept while base select set
  pll_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (pllWrite and bcs_r) |=> pllPwr_r)
    else $error("pll power cleared with base select set");

  bcs_lock_a: assert property (@(posedge clock) disable iff (!rstn)
    (pllWrite and !pllPwr_r) |=> !bcs_r)
    else $error("base select set while pll unpowered");

  pre_lock_a: assert property (@(posedge clock) disable iff (!rstn)
    pllPwr_r |=> $stable(pre_r))
    else $error("prescaler changed while pll powered");

  vpr_lock_a: assert property (@(posedge clock) disable iff (!rstn)
    pllPwr_r |=> $stable(vpr_r))
    else $error("vco range changed while pll powered");

  pre_mult_a: assert property (@(posedge clock) disable iff (!rstn)
    ##1 prescaleMult == (4'h1 << $past(pre_r)))
    else $error("prescaler multiplier wrong");

  vpr_mult_a: assert property (@(posedge clock) disable iff (!rstn)
    ##1 vcoRangeMult == 3'(4'h1 << $past(vpr_r)))
    else $error("vco range multiplier wrong");

  int_stop_a: assert property (@(posedge clock) disable iff (!rstn)
    (stopMode && setup_r[`OSS_SETUP_ICLKDIS]) |=> !internalOscEn)
    else $error("internal oscillator ran in stop with disable set");

  int_run_a: assert property (@(posedge clock) disable iff (!rstn)
    !stopMode |=> internalOscEn)
    else $error("internal oscillator off outside stop mode");

  rc_keep_a: assert property (@(posedge clock) disable iff (!rstn)
    (stopMode && refSel == `OSS_REF_RC) |=> rcOscEn == $past(setup_r[`OSS_SETUP_RCKEEP]))
    else $error("rc oscillator stop control wrong");

  x_keep_a: assert property (@(posedge clock) disable iff (!rstn)
    (stopMode && refSel == `OSS_REF_XTAL) |=> crystalOscEn == $past(setup_r[`OSS_SETUP_XKEEP]))
    else $error("crystal oscillator stop control wrong");

  pin_src_a: assert property (@(posedge clock) disable iff (!rstn)
    (optLoaded_r && refSel != `OSS_REF_XTAL) |=> oscOutPin == $past(busClkLevel))
    else $error("oscillator pin not at bus clock");

  ref_int_a: assert property (@(posedge clock) disable iff (!rstn)
    (optLoaded_r && refSel == `OSS_REF_INT) |=> pllRefClock == $past(internalOscClk))
    else $error("reference clock not at internal oscillator");

  ref_rc_a: assert property (@(posedge clock) disable iff (!rstn)
    (optLoaded_r && refSel == `OSS_REF_RC) |=> pllRefClock == $past(rcOscClk))
    else $error("reference clock not at rc oscillator");

  ref_xtal_a: assert property (@(posedge clock) disable iff (!rstn)
    (optLoaded_r && refSel == `OSS_REF_XTAL) |=> pllRefClock == $past(crystalOscClk))
    else $error("reference clock not at crystal oscillator");

  ref_none_a: assert property (@(posedge clock) disable iff (!rstn)
    (optLoaded_r && refSel == `OSS_REF_NONE) |=> !pllRefClock)
    else $error("reference clock driven on unused select code");

  // crystal drive inverted on the pin
  pin_xtal_a: assert property (@(posedge clock) disable iff (!rstn)
    (optLoaded_r && refSel == `OSS_REF_XTAL) |=> oscOutPin == !$past(crystalDrive))
    else $error("oscillator pin not at inverted crystal drive");

  // option word never changes after capture
  opt_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    optLoaded_r |=> $stable(option_r))
    else $error("option word changed after capture");

  setup_wr_a: assert property (@(posedge clock) disable iff (!rstn)
    (wrByte0 && hitSetup) |=> setup_r == ($past(wd) & `OSS_SETUP_MASK))
    else $error("setup register write lost");

  // read data stays zero outside an answer
  wb_data_a: assert property (@(posedge clock) disable iff (!rstn)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data driven outside acknowledge");

  // bus answers in one cycle
  wb_ack_a: assert property (@(posedge clock) disable iff (!rstn)
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack timing wrong");

endmodule

/* rtl/oss_defines.svh */
// register map, field positions, reset values and encodings of the oscillator source select block
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define OSS_IDX_SETUP        16'h001D
`define OSS_IDX_OPTION       16'hFFCF
`define OSS_IDX_PLL          16'h0036
`define OSS_ADDR_W           18

// ==========================================================
// stop_and_timebase_setup fields
`define OSS_SETUP_ICLKDIS    4
`define OSS_SETUP_RCKEEP     3
`define OSS_SETUP_XKEEP      2
`define OSS_SETUP_TBHI       1
`define OSS_SETUP_TBLO       0
`define OSS_SETUP_RESET      8'h00
`define OSS_SETUP_MASK       8'h1F

// ==========================================================
// reference_option_word fields
`define OSS_OPT_REFHI        1
`define OSS_OPT_REFLO        0

// ==========================================================
// pll_control fields
`define OSS_PLL_PWR          5
`define OSS_PLL_BCS          4
`define OSS_PLL_VPRHI        3
`define OSS_PLL_VPRLO        2
`define OSS_PLL_PREHI        1
`define OSS_PLL_PRELO        0
`define OSS_PLL_RESET        8'h00

// ==========================================================
// source codes on the timebase select and on the option word
`define OSS_TB_INT           2'h0
`define OSS_TB_RC            2'h1
`define OSS_TB_XTAL          2'h2
`define OSS_TB_NONE          2'h3
`define OSS_REF_NONE         2'h0
`define OSS_REF_INT          2'h1
`define OSS_REF_RC           2'h2
`define OSS_REF_XTAL         2'h3

`endif

/* rtl/oss_pkg.sv */
// types shared by the oscillator source select block
package oss_pkg;

  typedef enum logic [1:0] {
    MUX_RUN,
    MUX_DRAIN,
    MUX_SETTLE
  } oss_mux_state_t;

  typedef logic [1:0] oss_sel_t;

endpackage

/* rtl/oss_clk_mux.sv */
// glitch-free selector of the timebase clock among three sampled oscillator levels
`timescale 1ns/10ps
`include "oss_defines.svh"

module oss_clk_mux (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rstn,
  // sources
  input  wire logic [2:0]     srcLevel,
  input  wire logic [2:0]     srcAllowed,
  input  wire oss_pkg::oss_sel_t sel,
  // timebase clock
  output logic                clkOut_r
);

  oss_pkg::oss_mux_state_t state_r;
  oss_pkg::oss_sel_t       curSel_r;

  // level of a source, low for the unused code or a source not offered
  function automatic logic srcOf(input oss_pkg::oss_sel_t s, input logic [2:0] lvl, input logic [2:0] ok);
    if (s == `OSS_TB_NONE) begin
      srcOf = 1'b0;
    end else begin
      srcOf = lvl[s] & ok[s];
    end
  endfunction

  logic curLvl;
  logic newLvl;
  assign curLvl = srcOf(curSel_r, srcLevel, srcAllowed);
  assign newLvl = srcOf(sel, srcLevel, srcAllowed);

  // ==========================================================
  // selection state
  // switch only at low phases
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r  <= oss_pkg::MUX_RUN;
      curSel_r <= `OSS_TB_INT;
    end else begin
      unique case (state_r)
        oss_pkg::MUX_RUN: begin
          if (sel != curSel_r && !curLvl) begin
            state_r <= oss_pkg::MUX_DRAIN;
          end
        end
        oss_pkg::MUX_DRAIN: begin
          curSel_r <= sel;
          state_r  <= oss_pkg::MUX_SETTLE;
        end
        oss_pkg::MUX_SETTLE: begin
          if (!curLvl) begin
            state_r <= oss_pkg::MUX_RUN;
          end
        end
        default: begin
          state_r <= oss_pkg::MUX_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // output
  // unused code drives low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clkOut_r <= 1'b0;
    end else if (state_r == oss_pkg::MUX_RUN && sel == curSel_r) begin
      clkOut_r <= curLvl;
    end else if (state_r == oss_pkg::MUX_RUN) begin
      clkOut_r <= curLvl;
    end else begin
      clkOut_r <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  // no output while switching
  mux_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    state_r == oss_pkg::MUX_DRAIN |=> !clkOut_r)
    else $error("timebase clock pulsed during source switch");

  mux_none_a: assert property (@(posedge clock) disable iff (!rstn)
    (curSel_r == `OSS_TB_NONE && state_r == oss_pkg::MUX_RUN) |=> !clkOut_r)
    else $error("timebase clock driven on unused select code");

  // the rc source, when not offered, never reaches the output
  tb_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    (curSel_r == `OSS_TB_RC && !srcAllowed[1]) |=> !clkOut_r)
    else $error("rc clock reached timebase without being reference");

  // new source followed only from a low level
  mux_settle_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == oss_pkg::MUX_SETTLE && !newLvl && curSel_r == sel) |=> state_r == oss_pkg::MUX_RUN)
    else $error("selector did not settle on a low new source");

endmodule

/* rtl/oss_osc_gate.sv */
// run/stop enables of the three oscillators
`timescale 1ns/10ps
`include "oss_defines.svh"

module oss_osc_gate (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rstn,
  // controls
  input  wire logic           stopMode,
  input  wire logic           iclkDisable,
  input  wire logic           rcKeep,
  input  wire logic           xtalKeep,
  input  wire oss_pkg::oss_sel_t refSel,
  // enables
  output logic                intOscEn_r,
  output logic                rcOscEn_r,
  output logic                xtalOscEn_r
);

  // ==========================================================
  // enables; rc and crystal are powered only as the reference
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intOscEn_r  <= 1'b1;
      rcOscEn_r   <= 1'b0;
      xtalOscEn_r <= 1'b0;
    end else begin
      intOscEn_r  <= !(stopMode && iclkDisable);
      rcOscEn_r   <= (refSel == `OSS_REF_RC) && (!stopMode || rcKeep);
      xtalOscEn_r <= (refSel == `OSS_REF_XTAL) && (!stopMode || xtalKeep);
    end
  end

endmodule

/* verification/test_oss_top.sv */
// self-checking testbench of the oscillator source select block
`timescale 1ns/10ps
`include "oss_defines.svh"

module test_oss_top;
  // ==================================================
  // design connections
  logic                   clock;
  logic                   rstn;
  logic                   wbCyc;
  logic                   wbStb;
  logic                   wbWe;
  logic [`OSS_ADDR_W-1:0] wbAdr;
  logic [3:0]             wbSel;
  logic [31:0]            wbDatI;
  logic [31:0]            wbDatO;
  logic                   wbAck;
  logic                   internalOscClk;
  logic                   rcOscClk;
  logic                   crystalOscClk;
  logic                   crystalDrive;
  logic                   busClkLevel;
  logic [7:0]             optionWord;
  logic                   stopMode;
  logic                   pllRefClock;
  logic                   timebaseRefClock;
  logic                   oscOutPin;
  logic                   internalOscEn;
  logic                   rcOscEn;
  logic                   crystalOscEn;
  logic                   pllPowerOn;
  logic                   baseClockSelect;
  logic [3:0]             prescaleMult;
  logic [2:0]             vcoRangeMult;
  // bench state
  logic                   run;
  logic [2:0]             lv;
  logic [7:0]             tick;
  int                     failCount;
  int                     checked;
  int                     cycles;

  oss_top uut (.clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .internalOscClk(internalOscClk), .rcOscClk(rcOscClk), .crystalOscClk(crystalOscClk),
    .crystalDrive(crystalDrive), .busClkLevel(busClkLevel), .optionWord(optionWord), .stopMode(stopMode),
    .pllRefClock(pllRefClock), .timebaseRefClock(timebaseRefClock), .oscOutPin(oscOutPin),
    .internalOscEn(internalOscEn), .rcOscEn(rcOscEn), .crystalOscEn(crystalOscEn), .pllPowerOn(pllPowerOn),
    .baseClockSelect(baseClockSelect), .prescaleMult(prescaleMult), .vcoRangeMult(vcoRangeMult));

  // ==================================================
  // clock and oscillator levels
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // sources toggle at rates a factor of two apart, or freeze so settled levels can be compared
  always @(posedge clock) begin
    tick <= tick + 8'h01;
    internalOscClk <= run ? tick[1] : lv[0];
    rcOscClk <= run ? tick[2] : lv[1];
    crystalOscClk <= run ? tick[3] : lv[2];
  end

  // a hung handshake must not stall the run forever
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount = failCount + 1;
      end_sim();
    end
  end

  // ==================================================
  // shared tasks
  task automatic end_sim();
    if (failCount == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failCount = failCount + 1;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatI <= {24'h00_0000, wd};
    wbSel <= 4'h1;
    // only the cycle ceiling ends a wait that never sees ack
    do begin
      @(posedge clock);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, wd, d);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 8'h00, d);
    chk(d, {24'h00_0000, exp});
  endtask

  // option word is only taken at the first edge after release
  task automatic do_reset(input logic [7:0] opt);
    @(posedge clock);
    optionWord <= opt;
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    waitc(3);
  endtask

  // ==================================================
  // scenarios
  task automatic t_regs();
    chk(internalOscEn, 1);
    chk(prescaleMult, 1);
    chk(vcoRangeMult, 1);
    chk(pllPowerOn, 0);
    rdchk(`OSS_IDX_SETUP, 8'h00);
    rdchk(`OSS_IDX_PLL, 8'h00);
    rdchk(`OSS_IDX_OPTION, 8'hA5);
    wr(`OSS_IDX_OPTION, 8'h5A);
    rdchk(`OSS_IDX_OPTION, 8'hA5);
    rdchk(16'h0100, 8'h00);
    wr(`OSS_IDX_SETUP, 8'hFF);
    rdchk(`OSS_IDX_SETUP, 8'h1F);
    wr(`OSS_IDX_SETUP, 8'h00);
  endtask

  task automatic t_pll();
    logic [7:0] wv [7];
    logic [7:0] ev [7];
    logic [1:0] vr;
    wv = '{8'h15, 8'h35, 8'h35, 8'h15, 8'h2A, 8'h00, 8'h00};
    ev = '{8'h05, 8'h25, 8'h35, 8'h35, 8'h25, 8'h05, 8'h00};
    // power first, then base select in a second write
    for (int i = 0; i < 7; i++) begin
      wr(`OSS_IDX_PLL, wv[i]);
      rdchk(`OSS_IDX_PLL, ev[i]);
      waitc(1);
      chk(pllPowerOn, ev[i][5]);
      chk(baseClockSelect, ev[i][4]);
      chk(prescaleMult, 4'h1 << ev[i][1:0]);
      chk(vcoRangeMult, 3'h1 << ev[i][3:2]);
    end
    for (int p = 0; p < 4; p++) begin
      vr = (p < 3) ? 2'(p) : 2'h0;
      wr(`OSS_IDX_PLL, {4'h0, vr, 2'(p)});
      waitc(2);
      chk(prescaleMult, 4'h1 << p);
      chk(vcoRangeMult, 3'h1 << vr);
    end
  endtask

  function automatic logic tbExp(input logic [1:0] s, input logic [1:0] r, input logic [2:0] l);
    case (s)
      `OSS_TB_INT: return l[0];
      `OSS_TB_RC: return (r == `OSS_REF_RC) & l[1];
      `OSS_TB_XTAL: return (r == `OSS_REF_XTAL) & l[2];
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_src(input logic [1:0] r);
    logic [2:0] pat;
    pat = (r == 2'h0) ? 3'h1 : 3'h1 << (r - 2'h1);
    do_reset({6'h00, r});
    waitc(2);
    chk(oscOutPin, r == `OSS_REF_XTAL);
    crystalDrive <= 1'b1;
    busClkLevel <= 1'b1;
    waitc(3);
    chk(oscOutPin, r != `OSS_REF_XTAL);
    crystalDrive <= 1'b0;
    busClkLevel <= 1'b0;
    stopMode <= 1'b1;
    waitc(3);
    chk(internalOscEn, 1);
    chk(rcOscEn, 0);
    chk(crystalOscEn, 0);
    wr(`OSS_IDX_SETUP, 8'h1C);
    waitc(3);
    chk(internalOscEn, 0);
    chk(rcOscEn, r == `OSS_REF_RC);
    chk(crystalOscEn, r == `OSS_REF_XTAL);
    stopMode <= 1'b0;
    waitc(3);
    chk(internalOscEn, 1);
    chk(rcOscEn, r == `OSS_REF_RC);
    for (int s = 0; s < 4; s++) begin
      wr(`OSS_IDX_SETUP, {6'h00, 2'(s)});
      run <= 1'b1;
      waitc(40);
      lv <= pat;
      run <= 1'b0;
      waitc(6);
      chk(pllRefClock, (r == 2'h0) ? 1'b0 : pat[r - 2'h1]);
      chk(timebaseRefClock, tbExp(2'(s), r, pat));
      lv <= ~pat;
      waitc(6);
      chk(pllRefClock, 1'b0);
      chk(timebaseRefClock, tbExp(2'(s), r, ~pat));
    end
  endtask

  // ==================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = '0;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    crystalDrive = 1'b0;
    busClkLevel = 1'b0;
    optionWord = 8'hA5;
    stopMode = 1'b0;
    run = 1'b1;
    lv = 3'h0;
    tick = 8'h00;
    failCount = 0;
    checked = 0;
    cycles = 0;
    do_reset(8'hA5);
    t_regs();
    t_pll();
    for (int r = 0; r < 4; r++) begin
      t_src(2'(r));
    end
    end_sim();
  end
endmodule
